/* design/aer_pkg.sv */
// shared constants for the correctable error reporting registers
package aer_pkg;

	// register byte offsets inside extended configuration space
	localparam logic [11:0] AER_COR_FLAGS_OFS   = 12'h110;
	localparam logic [11:0] AER_COR_MASKS_OFS   = 12'h114;
	localparam logic [11:0] AER_CAP_CTRL_OFS    = 12'h118;
	localparam logic [11:0] AER_HDR_DW0_OFS     = 12'h11c;
	localparam logic [11:0] AER_HDR_DW1_OFS     = 12'h120;
	localparam logic [11:0] AER_HDR_DW2_OFS     = 12'h124;
	localparam logic [11:0] AER_HDR_DW3_OFS     = 12'h128;

	// correctable status / mask bit positions
	localparam int ADV_NONFATAL_BIT  = 13;
	localparam int REPLAY_TIMER_BIT  = 12;
	localparam int REPLAY_ROLL_BIT   = 8;
	localparam int LINK_PKT_BIT      = 7;
	localparam int TRANS_PKT_BIT     = 6;
	localparam int RX_DECODE_BIT     = 0;

	// implemented bits of status and mask, everything else reserved
	localparam logic [31:0] COR_IMPL_BITS   = 32'h0000_31c1;
	localparam logic [31:0] COR_FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] COR_MASKS_RESET = 32'h0000_2000;

	// capability and control field layout
	localparam int CRC_CHECK_EN_BIT   = 8;
	localparam int CRC_CHECK_CAP_BIT  = 7;
	localparam int CRC_GEN_EN_BIT     = 6;
	localparam int CRC_GEN_CAP_BIT    = 5;
	localparam int FIRST_PTR_MSB      = 4;
	localparam int FIRST_PTR_W        = 5;
	localparam logic [31:0] CAP_CTRL_RESET = 32'h0000_00a0;

	// header log
	localparam int HDR_DWORDS         = 4;
	localparam logic [31:0] HDR_RESET = 32'h0000_0000;

endpackage : aer_pkg

/* design/aer_flag_cell.sv */
`timescale 1ns/10ps
// one sticky write-one-to-clear status bit with its block (mask) input
module aer_flag_cell (
	input  wire logic core_clk,
	input  wire logic fundamental_reset_n_n,
	input  wire logic evt,
	input  wire logic blk,
	input  wire logic clr,
	output logic      flag
);
	logic flag_nxt;     // next sticky value

	// a new event wins over a clear arriving in the same cycle
	assign flag_nxt = (flag & ~clr) | (evt & ~blk);      // [RQ1] [RQ9] [RQ21]

	// sticky: only the fundamental reset or a write-one clear returns it to zero
	always_ff @(posedge core_clk) begin
		if (!fundamental_reset_n_n) begin
			flag <= 1'b0;                                 // [RQ17]
		end else begin
			flag <= flag_nxt;
		end
	end
endmodule : aer_flag_cell

/* design/aer_cor_regs.sv */
`timescale 1ns/10ps
// Function
// RQ1: status bits clear only by writing one
// RQ2: advisory nonfatal event sets bit 13
// RQ3: replay timer expiry sets bit 12
// RQ4: replay count rollover sets bit 8
// RQ5: decode error during DLLP sets bit 7
// RQ6: decode error during TLP sets bit 6
// RQ7: any decode error sets bit 0
// RQ8: reserved status bits read as zero
// RQ9: mask blocks status, message, log, pointer
// RQ10: mask bits align, reset 0000 2000h
// RQ11: control bit 8 enables CRC checking
// RQ12: bit 7 reads one, check capable
// RQ13: control bit 6 enables CRC generation
// RQ14: bit 5 reads one, generate capable
// RQ15: bits 4:0 hold first error pointer
// RQ16: control register resets 0000 00A0h, reserved zero
// RQ17: sticky fields cleared by fundamental reset only
// RQ18: capture header of latest erroring TLP
// RQ19: earliest transmitted byte in low byte
// RQ20: header log resets zero, fundamental only
// RQ21: zero writes, read-only writes have no effect
module aer_cor_regs (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         platform_reset_in_n,
	input  wire logic         global_reset_in_n,
	input  wire logic         cfg_wr_en,
	input  wire logic         cfg_rd_en,
	input  wire logic [11:0]  cfg_addr,
	input  wire logic [31:0]  cfg_wr_data,
	input  wire logic [3:0]   cfg_byte_en,
	output logic      [31:0]  cfg_rd_data,
	output logic              cfg_rd_valid,
	input  wire logic         advisory_nonfatal_evt,
	input  wire logic         replay_timer_expired_evt,
	input  wire logic         replay_rollover_evt,
	input  wire logic         rx_decode_fault_evt,
	input  wire logic         rx_in_link_packet,
	input  wire logic         rx_in_transaction_packet,
	input  wire logic         uncor_err_evt,
	input  wire logic [4:0]   uncor_err_pos,
	input  wire logic         uncor_err_masked,
	input  wire logic         uncor_status_empty,
	input  wire logic         hdr_valid,
	input  wire logic [127:0] hdr_bytes,
	output logic              cor_err_msg,
	output logic              end_crc_check_enable,
	output logic              end_crc_generate_enable,
	output logic              fundamental_reset_n
);
	import aer_pkg::*;

	// six sticky flags, their masks,
	// two crc enables, a first pointer
	// and a four dword header log

	// reset pin synchronisers, first stage read only by the second
	logic                plat_meta_r;      // platform reset, stage one
	logic                plat_sync_r;      // platform reset, stage two
	logic                glob_meta_r;      // global reset, stage one
	logic                glob_sync_r;      // global reset, stage two
	logic                fundamental_reset_n_n_w;         // combined fundamental reset, active low

	// sticky state survives rst_n;
	// only the pins bring it back
	// register state
	logic [31:0]         flags_w;          // status bits from the flag cells
	logic [31:0]         masks_r;          // mask register
	logic [31:0]         masks_nxt;
	logic                chk_en_r;         // crc check enable
	logic                chk_en_nxt;
	logic                gen_en_r;         // crc generate enable
	logic                gen_en_nxt;
	logic [4:0]          first_ptr_r;      // first error pointer
	logic [4:0]          first_ptr_nxt;
	logic [31:0]         hdr_log_r [HDR_DWORDS];   // captured header dwords
	logic [31:0]         hdr_dw_w  [HDR_DWORDS];   // incoming header, packed

	// decode and return are nets
	// around two flops
	// bus side
	logic [31:0]         be_mask_w;        // byte enables widened to bits
	logic [31:0]         wr_bits_w;        // write data limited to enabled lanes
	logic                hit_flags_w;
	logic                hit_masks_w;
	logic                hit_ctrl_w;
	logic                hit_hdr_w;
	logic [1:0]          hdr_idx_w;        // which header dword is addressed
	logic [31:0]         ctrl_view_w;      // capability/control as read
	logic [31:0]         rd_mux_w;         // selected read value
	logic [31:0]         rd_data_r;
	logic                rd_valid_r;

	// events are one-cycle pulses
	// on this same clock
	// error event routing
	logic [31:0]         evt_vec_w;        // events in status bit positions
	logic [31:0]         clr_vec_w;        // write-one clears
	logic                cor_hit_w;        // any unmasked correctable event
	logic                uncor_hit_w;      // unmasked uncorrectable event
	logic                msg_r;
	logic                hdr_load_w;       // header log loads this cycle
	logic                ptr_load_w;       // first pointer loads this cycle

	// no reset here: the pins are the
	// reset, held low at power-up so
	// the unknowns flush out
	// two-flop synchronisers on the asynchronous reset pins
	always_ff @(posedge core_clk) begin
		plat_meta_r <= platform_reset_in_n;
		plat_sync_r <= plat_meta_r;
		glob_meta_r <= global_reset_in_n;
		glob_sync_r <= glob_meta_r;
	end

	// and of two active-low levels
	// is an or of the asserts
	// fundamental reset asserts whenever either source asserts
	assign fundamental_reset_n_n_w = plat_sync_r & glob_sync_r;              // [RQ17]

	// other blocks take their sticky
	// reset from this flop
	// registered copy for the rest of the function
	always_ff @(posedge core_clk) begin
		fundamental_reset_n <= fundamental_reset_n_n_w;
	end


	// exact match only: no aliasing,
	// at the cost of a few comparators
	// odd offsets hit nothing
	// --- address decode ---
	assign hit_flags_w = (cfg_addr == AER_COR_FLAGS_OFS);
	assign hit_masks_w = (cfg_addr == AER_COR_MASKS_OFS);
	assign hit_ctrl_w  = (cfg_addr == AER_CAP_CTRL_OFS);
	// header dwords occupy four consecutive aligned words
	assign hit_hdr_w   = (cfg_addr == AER_HDR_DW0_OFS) | (cfg_addr == AER_HDR_DW1_OFS)
	                   | (cfg_addr == AER_HDR_DW2_OFS) | (cfg_addr == AER_HDR_DW3_OFS);
	assign hdr_idx_w   = (cfg_addr == AER_HDR_DW0_OFS) ? 2'h0 :
	                     (cfg_addr == AER_HDR_DW1_OFS) ? 2'h1 :
	                     (cfg_addr == AER_HDR_DW2_OFS) ? 2'h2 : 2'h3;

	// a lane left off keeps its bits
	// byte enables steer every write, lane by lane
	assign be_mask_w = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
	                    {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
	assign wr_bits_w = cfg_wr_data & be_mask_w;

	// one decode fault may set bit 0
	// and bit 6 or 7 in one cycle
	// qualifiers are levels
	// --- event vector in status positions ---
	always_comb begin
		evt_vec_w                   = 32'h0000_0000;
		evt_vec_w[ADV_NONFATAL_BIT] = advisory_nonfatal_evt;                      // [RQ2]
		evt_vec_w[REPLAY_TIMER_BIT] = replay_timer_expired_evt;                   // [RQ3]
		evt_vec_w[REPLAY_ROLL_BIT]  = replay_rollover_evt;                        // [RQ4]
		evt_vec_w[LINK_PKT_BIT]     = rx_decode_fault_evt & rx_in_link_packet;    // [RQ5]
		evt_vec_w[TRANS_PKT_BIT]    = rx_decode_fault_evt
		                            & rx_in_transaction_packet;                   // [RQ6]
		evt_vec_w[RX_DECODE_BIT]    = rx_decode_fault_evt;                        // [RQ7]
	end

	// reserved positions never clear,
	// they have nothing to clear
	// only a one written to an implemented position clears; zeros do nothing
	assign clr_vec_w = (cfg_wr_en & hit_flags_w) ? (wr_bits_w & COR_IMPL_BITS)
	                                             : 32'h0000_0000;           // [RQ1] [RQ21]

	// set wins over a clear in the
	// same cycle, so no event is lost
	// one sticky cell per implemented status bit, reserved bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (COR_IMPL_BITS[gi]) begin : g_impl
				aer_flag_cell u_cell (
					.core_clk (core_clk),
					.fundamental_reset_n_n   (fundamental_reset_n_n_w),
					.evt      (evt_vec_w[gi]),
					.blk      (masks_r[gi]),
					.clr      (clr_vec_w[gi]),
					.flag     (flags_w[gi])
				);
			end else begin : g_rsvd
				assign flags_w[gi] = 1'b0;                        // [RQ8]
			end
		end
	endgenerate


	// mask gates all side effects
	// before any flop sees them
	// --- masking of side effects ---
	// a masked event neither raises a message nor loads the log
	assign cor_hit_w   = |(evt_vec_w & ~masks_r & COR_IMPL_BITS);               // [RQ9]
	assign uncor_hit_w = uncor_err_evt & ~uncor_err_masked;                     // [RQ9]
	assign hdr_load_w  = hdr_valid & (cor_hit_w | uncor_hit_w);                 // [RQ18]
	// pointer only follows the first unmasked error while status is empty
	assign ptr_load_w  = uncor_hit_w & uncor_status_empty;                      // [RQ15]

	// reserved mask bits stay zero
	// whatever software writes
	// --- mask register next value: only implemented bits are writable ---
	assign masks_nxt = (cfg_wr_en & hit_masks_w)
	                 ? ((masks_r & ~(be_mask_w & COR_IMPL_BITS))
	                   | (wr_bits_w & COR_IMPL_BITS))
	                 : masks_r;                                                 // [RQ10] [RQ21]

	// advisory starts masked
	// mask register, sticky
	always_ff @(posedge core_clk) begin
		if (!fundamental_reset_n_n_w) begin
			masks_r <= COR_MASKS_RESET;                                         // [RQ10] [RQ17]
		end else begin
			masks_r <= masks_nxt;
		end
	end

	// a write with lane 1 off leaves
	// checking alone, lane 0 off
	// leaves generation alone
	// --- capability/control: enables sit in byte lanes 0 and 1 ---
	assign chk_en_nxt = (cfg_wr_en & hit_ctrl_w & cfg_byte_en[1])
	                  ? cfg_wr_data[CRC_CHECK_EN_BIT] : chk_en_r;               // [RQ11]
	assign gen_en_nxt = (cfg_wr_en & hit_ctrl_w & cfg_byte_en[0])
	                  ? cfg_wr_data[CRC_GEN_EN_BIT] : gen_en_r;                 // [RQ13]
	// pointer is hardware-updated only, software writes leave it alone
	assign first_ptr_nxt = ptr_load_w ? uncor_err_pos : first_ptr_r;            // [RQ15] [RQ21]

	// pointer resets to zero with
	// the rest of the register
	// control fields, sticky
	always_ff @(posedge core_clk) begin
		if (!fundamental_reset_n_n_w) begin
			chk_en_r    <= CAP_CTRL_RESET[CRC_CHECK_EN_BIT];                    // [RQ16] [RQ17]
			gen_en_r    <= CAP_CTRL_RESET[CRC_GEN_EN_BIT];
			first_ptr_r <= CAP_CTRL_RESET[FIRST_PTR_MSB:0];
		end else begin
			chk_en_r    <= chk_en_nxt;
			gen_en_r    <= gen_en_nxt;
			first_ptr_r <= first_ptr_nxt;
		end
	end

	// fed from next values so the pins
	// change on the same edge as the
	// register the software reads
	// enables drive the crc engines elsewhere in the function
	always_ff @(posedge core_clk) begin
		if (!fundamental_reset_n_n_w) begin
			end_crc_check_enable    <= CAP_CTRL_RESET[CRC_CHECK_EN_BIT];
			end_crc_generate_enable <= CAP_CTRL_RESET[CRC_GEN_EN_BIT];
		end else begin
			end_crc_check_enable    <= chk_en_nxt;                          // [RQ11]
			end_crc_generate_enable <= gen_en_nxt;                          // [RQ13]
		end
	end

	// writes to capability bits
	// have nowhere to land
	// capability bits are constant ones, reserved bits zero
	always_comb begin
		ctrl_view_w                        = 32'h0000_0000;                     // [RQ16]
		ctrl_view_w[CRC_CHECK_EN_BIT]      = chk_en_r;
		ctrl_view_w[CRC_CHECK_CAP_BIT]     = 1'b1;                              // [RQ12]
		ctrl_view_w[CRC_GEN_EN_BIT]        = gen_en_r;
		ctrl_view_w[CRC_GEN_CAP_BIT]       = 1'b1;                              // [RQ14]
		ctrl_view_w[FIRST_PTR_MSB:0]       = first_ptr_r;                       // [RQ15]
	end


	// log is read-only to software;
	// only an unmasked error loads it
	// limitation: last error wins
	// --- header log ---
	// hdr_bytes[7:0] is the first byte on the wire, so byte k of dword d
	// is wire byte 4*d+k and the earliest lands in the low byte
	generate
		for (gi = 0; gi < HDR_DWORDS; gi++) begin : g_hdr
			assign hdr_dw_w[gi] = hdr_bytes[gi*32 +: 32];                       // [RQ19]
		end
	endgenerate

	// no per-dword enables, which
	// keeps the load a single strobe
	// whole header replaced on each unmasked error with hdr_valid; a 3dw header
	// still writes dword 3 with whatever the link layer supplies
	always_ff @(posedge core_clk) begin
		for (int d = 0; d < HDR_DWORDS; d++) begin
			if (!fundamental_reset_n_n_w) begin
				hdr_log_r[d] <= HDR_RESET;                                      // [RQ20]
			end else if (hdr_load_w) begin
				hdr_log_r[d] <= hdr_dw_w[d];                                    // [RQ18]
			end
		end
	end


	// read mux is combinational,
	// only its result is registered
	// so reads never disturb state
	// --- read path ---
	// unmapped offsets read as zero; reads have no side effect
	assign rd_mux_w = hit_flags_w ? flags_w :                                   // [RQ8]
	                  hit_masks_w ? masks_r :
	                  hit_ctrl_w  ? ctrl_view_w :
	                  hit_hdr_w   ? hdr_log_r[hdr_idx_w] : 32'h0000_0000;

	// data holds until the next read
	// valid stands one cycle
	// read answer one cycle after the request
	always_ff @(posedge core_clk) begin
		if (!rst_n || !fundamental_reset_n_n_w) begin
			rd_data_r  <= 32'h0000_0000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r  <= cfg_rd_en ? rd_mux_w : rd_data_r;
			rd_valid_r <= cfg_rd_en;
		end
	end

	// not queued: the message engine
	// must take each pulse as it comes
	// several events in a cycle: one pulse
	// correctable error message request, one pulse per unmasked event cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n || !fundamental_reset_n_n_w) begin
			msg_r <= 1'b0;
		end else begin
			msg_r <= cor_hit_w;                                                 // [RQ9]
		end
	end

	// outputs come straight from flops
	// so no decode glitch reaches
	// the config port
	assign cfg_rd_data  = rd_data_r;
	assign cfg_rd_valid = rd_valid_r;
	assign cor_err_msg  = msg_r;

endmodule : aer_cor_regs

/* tb/aer_cor_regs_assertions.sv */
`timescale 1ns/10ps
// port-level checks of the correctable error register bank
module aer_cor_regs_chk
	import aer_pkg::*;
(
	input wire logic         core_clk,
	input wire logic         rst_n,
	input wire logic         platform_reset_in_n,
	input wire logic         global_reset_in_n,
	input wire logic         cfg_wr_en,
	input wire logic         cfg_rd_en,
	input wire logic [11:0]  cfg_addr,
	input wire logic [31:0]  cfg_wr_data,
	input wire logic [3:0]   cfg_byte_en,
	input wire logic [31:0]  cfg_rd_data,
	input wire logic         advisory_nonfatal_evt,
	input wire logic         replay_timer_expired_evt,
	input wire logic         replay_rollover_evt,
	input wire logic         rx_decode_fault_evt,
	input wire logic         uncor_err_evt,
	input wire logic [4:0]   uncor_err_pos,
	input wire logic         uncor_err_masked,
	input wire logic         uncor_status_empty,
	input wire logic         hdr_valid,
	input wire logic [127:0] hdr_bytes,
	input wire logic         cor_err_msg,
	input wire logic         end_crc_check_enable,
	input wire logic         end_crc_generate_enable,
	input wire logic         fundamental_reset_n
);
	default clocking @(posedge core_clk); endclocking
	// either reset hides state, so stay quiet while one is low
	default disable iff (!rst_n || !fundamental_reset_n);

	// a lone replay expiry that the bank accepted
	sequence replay_taken_s;
		replay_timer_expired_evt && !advisory_nonfatal_evt && !replay_rollover_evt
			&& !rx_decode_fault_evt && !uncor_err_evt ##1 cor_err_msg;
	endsequence
	// read request for one offset
	sequence read_at_s(logic [11:0] ofs);
		cfg_rd_en && cfg_addr == ofs;
	endsequence

	replay_sets_flag_a: assert property (
		replay_taken_s ##0 read_at_s(AER_COR_FLAGS_OFS) |=> cfg_rd_data[REPLAY_TIMER_BIT])
		else $error("replay expiry did not show in the flags");
	flag_one_clears_a: assert property (
		cfg_wr_en && cfg_addr == AER_COR_FLAGS_OFS && cfg_byte_en[1] && cfg_wr_data[12]
		&& !replay_timer_expired_evt ##1 read_at_s(AER_COR_FLAGS_OFS)
		|=> !cfg_rd_data[REPLAY_TIMER_BIT])
		else $error("writing one left the replay flag set");
	flag_rsvd_zero_a: assert property (
		read_at_s(AER_COR_FLAGS_OFS) |=> (cfg_rd_data & ~COR_IMPL_BITS) == 32'h0)
		else $error("reserved flag bits read nonzero");
	mask_rsvd_zero_a: assert property (
		read_at_s(AER_COR_MASKS_OFS) |=> (cfg_rd_data & ~COR_IMPL_BITS) == 32'h0)
		else $error("reserved mask bits read nonzero");
	ctrl_fixed_bits_a: assert property (
		read_at_s(AER_CAP_CTRL_OFS) |=> cfg_rd_data[31:9] == 23'h0
		&& cfg_rd_data[CRC_CHECK_CAP_BIT] && cfg_rd_data[CRC_GEN_CAP_BIT])
		else $error("capability bits or reserved control bits wrong");
	check_enable_a: assert property (
		cfg_wr_en && cfg_addr == AER_CAP_CTRL_OFS && cfg_byte_en[1]
		|=> end_crc_check_enable == $past(cfg_wr_data[CRC_CHECK_EN_BIT]))
		else $error("check enable did not follow the write");
	gen_enable_a: assert property (
		cfg_wr_en && cfg_addr == AER_CAP_CTRL_OFS && cfg_byte_en[0]
		|=> end_crc_generate_enable == $past(cfg_wr_data[CRC_GEN_EN_BIT]))
		else $error("generate enable did not follow the write");
	msg_has_cause_a: assert property (
		cor_err_msg |-> $past(advisory_nonfatal_evt || replay_timer_expired_evt
		|| replay_rollover_evt || rx_decode_fault_evt))
		else $error("message without a correctable event");
	hdr_capture_a: assert property (
		hdr_valid && uncor_err_evt && !uncor_err_masked ##1 read_at_s(AER_HDR_DW0_OFS)
		|=> cfg_rd_data == $past(hdr_bytes[31:0], 2))
		else $error("first header dword not captured");
	first_ptr_a: assert property (
		uncor_err_evt && !uncor_err_masked && uncor_status_empty ##1
		read_at_s(AER_CAP_CTRL_OFS) |=> cfg_rd_data[4:0] == $past(uncor_err_pos, 2))
		else $error("first error pointer not loaded");
	fundamental_reset_n_follows_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(platform_reset_in_n && global_reset_in_n) |-> ##[1:4] !fundamental_reset_n)
		else $error("pin reset did not reach the fundamental reset");
endmodule : aer_cor_regs_chk

bind aer_cor_regs aer_cor_regs_chk u_chk (.*);

/* tb/aer_link_model.sv */
`timescale 1ns/10ps
// stand-in for the link and physical layers that raise error events
module aer_link_model (
	output logic         advisory_nonfatal_evt,
	output logic         replay_timer_expired_evt,
	output logic         replay_rollover_evt,
	output logic         rx_decode_fault_evt,
	output logic         rx_in_link_packet,
	output logic         rx_in_transaction_packet,
	output logic         uncor_err_evt,
	output logic [4:0]   uncor_err_pos,
	output logic         uncor_err_masked,
	output logic         uncor_status_empty,
	output logic         hdr_valid,
	output logic [127:0] hdr_bytes
);
	// one call per cycle, from the falling edge; events last that cycle only
	task automatic put(input logic [7:0] ev, input logic [4:0] pos, input logic empty,
		input logic [127:0] hdr, input logic msk = 1'b0);
		{hdr_valid, uncor_err_evt, rx_in_transaction_packet, rx_in_link_packet,
			rx_decode_fault_evt, replay_rollover_evt, replay_timer_expired_evt,
			advisory_nonfatal_evt} = ev;
		uncor_err_pos      = pos;
		uncor_status_empty = empty;
		uncor_err_masked   = msk;
		// first wire byte in the low lane; stale lanes flip so they never look valid
		hdr_bytes = ev[7] ? hdr : ~hdr_bytes;
	endtask : put
endmodule : aer_link_model

/* tb/aer_cor_regs_test.sv */
`timescale 1ns/10ps
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", name, exp, got); end end
// register bank test through the config port and the link model
module aer_cor_regs_test;
	import aer_pkg::*;
	logic         core_clk = 1'b0;
	logic         rst_n, platform_reset_in_n, global_reset_in_n;
	logic         cfg_wr_en, cfg_rd_en, cfg_rd_valid, cor_err_msg;
	logic [11:0]  cfg_addr;
	logic [31:0]  cfg_wr_data, cfg_rd_data, seen_data;
	logic [3:0]   cfg_byte_en;
	logic         advisory_nonfatal_evt, replay_timer_expired_evt, replay_rollover_evt;
	logic         rx_decode_fault_evt, rx_in_link_packet, rx_in_transaction_packet;
	logic         uncor_err_evt, uncor_err_masked, uncor_status_empty, hdr_valid;
	logic [4:0]   uncor_err_pos;
	logic [127:0] hdr_bytes;
	logic         end_crc_check_enable, end_crc_generate_enable, fundamental_reset_n;
	logic         seen_valid, seen_msg, msg_at_rd;
	int           error_cnt = 0;
	int           n_compared = 0;
	int           cyc_cnt = 0;
	logic [127:0] hdr_a = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
	logic [11:0]  ofs[7] = '{12'h110, 12'h114, 12'h118, 12'h11c, 12'h120, 12'h124, 12'h128};
	logic [31:0]  rstv[7] = '{32'h0, 32'h2000, 32'ha0, 32'h0, 32'h0, 32'h0, 32'h0};
	// event bits: adv, replay, roll, decode, in dllp, in tlp, uncor, hdr valid
	logic [7:0]   evs[6] = '{8'h01, 8'h82, 8'h04, 8'h18, 8'h28, 8'h08};
	logic [31:0]  flg[6] = '{32'h2000, 32'h1000, 32'h100, 32'h81, 32'h41, 32'h1};

	aer_cor_regs dut (.*);
	aer_link_model u_link (.*);

	// free-running clock
	always #5 core_clk = ~core_clk;

	// one cycle: keep the last answer, then drive bus and link together
	task automatic cyc(input logic r, input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [7:0] ev = 8'h0, input logic [4:0] pos = 5'h0,
		input logic empty = 1'b1, input logic [127:0] hdr = 128'h0, input logic msk = 1'b0);
		@(negedge core_clk);
		seen_valid  = cfg_rd_valid;
		seen_data   = cfg_rd_data;
		seen_msg    = cor_err_msg;
		cfg_rd_en   = r;
		cfg_wr_en   = w;
		cfg_addr    = a;
		cfg_wr_data = d;
		u_link.put(ev, pos, empty, hdr, msk);
		@(posedge core_clk);
	endtask : cyc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		cyc(1'b0, 1'b1, a, d);
	endtask : wr
	// read then one idle cycle, answer checked when it stands
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		cyc(1'b1, 1'b0, a, 32'h0);
		msg_at_rd = seen_msg;
		cyc(1'b0, 1'b0, a, 32'h0);
		`CHK("read valid", 1'b1, seen_valid)
		`CHK($sformatf("reg %h", a), e, seen_data)
	endtask : rd
	task automatic fire(input logic [7:0] ev, input logic [4:0] pos = 5'h0,
		input logic empty = 1'b1, input logic [127:0] hdr = 128'h0, input logic msk = 1'b0);
		cyc(1'b0, 1'b0, 12'h0, 32'h0, ev, pos, empty, hdr, msk);
	endtask : fire
	// pins held low well past the synchroniser depth
	task automatic pin_reset(input logic p, input logic g);
		platform_reset_in_n <= p;
		global_reset_in_n   <= g;
		repeat (5) fire(8'h0);
		`CHK("fundamental reset", 1'b0, fundamental_reset_n)
		platform_reset_in_n <= 1'b1;
		global_reset_in_n   <= 1'b1;
		repeat (5) fire(8'h0);
		`CHK("fundamental reset", 1'b1, fundamental_reset_n)
	endtask : pin_reset
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	// hang guard, well above the roughly 190 cycles needed
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			error_cnt++;
			end_of_test();
		end
	end

	initial begin
		{rst_n, platform_reset_in_n, global_reset_in_n, cfg_rd_en, cfg_wr_en} = 5'h0;
		{cfg_addr, cfg_wr_data, cfg_byte_en} = '0;
		cfg_byte_en = 4'hf;
		u_link.put(8'h0, 5'h0, 1'b1, 128'h0);
		pin_reset(1'b0, 1'b0);
		rst_n <= 1'b1;
		repeat (3) fire(8'h0);
		foreach (ofs[i]) rd(ofs[i], rstv[i]);
		rd(12'h200, 32'h0);
		wr(AER_COR_MASKS_OFS, 32'hffff_ffff);
		rd(AER_COR_MASKS_OFS, COR_IMPL_BITS);
		wr(AER_COR_MASKS_OFS, 32'h0);
		// each event alone: set, survive a zero write, clear by one
		for (int i = 0; i < 6; i++) begin
			fire(evs[i], 5'h0, 1'b1, hdr_a);
			rd(AER_COR_FLAGS_OFS, flg[i]);
			`CHK("message", 1'b1, msg_at_rd)
			wr(AER_COR_FLAGS_OFS, ~flg[i]);
			rd(AER_COR_FLAGS_OFS, flg[i]);
			wr(AER_COR_FLAGS_OFS, flg[i]);
			rd(AER_COR_FLAGS_OFS, 32'h0);
		end
		for (int k = 0; k < 4; k++) rd(ofs[k+3], hdr_a[32*k +: 32]);
		// everything blocked: no flag, message or log change
		wr(AER_COR_MASKS_OFS, COR_IMPL_BITS);
		fire(8'hbf, 5'h0, 1'b1, ~hdr_a);
		rd(AER_COR_FLAGS_OFS, 32'h0);
		`CHK("message", 1'b0, msg_at_rd)
		rd(AER_HDR_DW0_OFS, hdr_a[31:0]);
		wr(AER_CAP_CTRL_OFS, 32'hffff_ffff);
		rd(AER_CAP_CTRL_OFS, 32'h0000_01e0);
		`CHK("check enable", 1'b1, end_crc_check_enable)
		`CHK("generate enable", 1'b1, end_crc_generate_enable)
		wr(AER_CAP_CTRL_OFS, 32'h0);
		rd(AER_CAP_CTRL_OFS, CAP_CTRL_RESET);
		`CHK("check enable", 1'b0, end_crc_check_enable)
		@(negedge core_clk) cfg_byte_en = 4'h1;
		wr(AER_CAP_CTRL_OFS, 32'hffff_ffff);
		rd(AER_CAP_CTRL_OFS, 32'h0000_00e0);
		@(negedge core_clk) cfg_byte_en = 4'hf;
		wr(AER_CAP_CTRL_OFS, 32'h0);
		wr(AER_HDR_DW0_OFS, 32'hffff_ffff);
		rd(AER_HDR_DW0_OFS, hdr_a[31:0]);
		// pointer loads on the first error only, log only on unmasked errors with a header
		fire(8'h40, 5'h05, 1'b1);
		rd(AER_CAP_CTRL_OFS, 32'h0000_00a5);
		fire(8'hc0, 5'h09, 1'b0, ~hdr_a);
		rd(AER_HDR_DW0_OFS, ~hdr_a[31:0]);
		rd(AER_CAP_CTRL_OFS, 32'h0000_00a5);
		fire(8'hc0, 5'h0b, 1'b1, hdr_a, 1'b1);
		rd(AER_HDR_DW0_OFS, ~hdr_a[31:0]);
		rd(AER_CAP_CTRL_OFS, 32'h0000_00a5);
		// plain reset keeps sticky state, either pin clears it
		wr(AER_COR_MASKS_OFS, 32'h0);
		fire(8'h02);
		rst_n <= 1'b0;
		fire(8'h0);
		rst_n <= 1'b1;
		fire(8'h0);
		rd(AER_COR_FLAGS_OFS, 32'h1000);
		rd(AER_COR_MASKS_OFS, 32'h0);
		pin_reset(1'b0, 1'b1);
		foreach (ofs[i]) rd(ofs[i], rstv[i]);
		wr(AER_COR_MASKS_OFS, 32'h0);
		fire(8'h02);
		pin_reset(1'b1, 1'b0);
		foreach (ofs[i]) rd(ofs[i], rstv[i]);
		end_of_test();
	end
endmodule : aer_cor_regs_test
